// [core/phyrs_defines.svh]
// Constants for the transceiver reset, power-mode and strap block
`ifndef PHYRS_DEFINES_SVH
`define PHYRS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PHYRS_ADDR_W 8
`define PHYRS_DATA_W 16
`define PHYRS_OFF_CTRL 8'h00
`define PHYRS_OFF_CFG 8'h04
`define PHYRS_OFF_STAT 8'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PHYRS_CTRL_SOFT_RST_BIT 15
`define PHYRS_CFG_SLEEP_BIT 6
`define PHYRS_STAT_RESET_BIT 15
`define PHYRS_STAT_PWRDN_BIT 14
`define PHYRS_STAT_SLEEP_BIT 13
`define PHYRS_STAT_MANAGED_BIT 12
`define PHYRS_STAT_PAUSE_BIT 8
`define PHYRS_STAT_ADDR_LSB 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PHYRS_RST_DATA 16'h0000
`define PHYRS_RST_ADDR 5'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PHYRS_CLK_MHZ 200
`define PHYRS_STRETCH_US 258
`define PHYRS_STRETCH_CYCLES (`PHYRS_STRETCH_US * `PHYRS_CLK_MHZ)
`define PHYRS_CNT_W 16

`endif

// [core/phyrs_pkg.sv]
// Types for the transceiver reset, power-mode and strap block
`include "phyrs_defines.svh"

package phyrs_pkg;

	typedef enum logic [1:0] {
		PHYRS_ST_HOLD = 2'b00,
		PHYRS_ST_STRETCH = 2'b01,
		PHYRS_ST_RUN = 2'b10
	} phyrs_state_e;

	typedef struct packed {
		phyrs_state_e state;
		logic [`PHYRS_CNT_W-1:0] cnt;
		logic soft_rst;
		logic cfg_sleep;
		logic managed;
		logic [4:0] addr;
		logic pause;
		logic phy_reset;
		logic sleep;
		logic pwr_down;
		logic [`PHYRS_DATA_W-1:0] rd_data;
	} phyrs_state_s;

	typedef struct packed {
		logic [`PHYRS_ADDR_W-1:0] addr;
		logic [`PHYRS_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} phyrs_bus_s;

endpackage : phyrs_pkg

// [core/phyrs_top.sv]
// Reset stretch, strap capture and power-mode selection for the transceiver
`timescale 1ns/1ps
`default_nettype none
`include "phyrs_defines.svh"

module phyrs_top
	import phyrs_pkg::*;
#(
	parameter int unsigned STRETCH_CYCLES = `PHYRS_STRETCH_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Board pins
	input wire logic i_ext_reset_b,
	input wire logic [4:0] i_addr_strap,
	input wire logic i_pause_strap,
	input wire logic i_sleep,
	input wire logic i_power_down_input,
	input wire logic i_management_disable_strap,
	// Register port
	input wire logic [`PHYRS_ADDR_W-1:0] i_reg_addr,
	input wire logic [`PHYRS_DATA_W-1:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [`PHYRS_DATA_W-1:0] o_reg_rdata,
	// Block outputs
	output logic o_phy_reset,
	output logic [4:0] o_mgmt_addr,
	output logic o_pause_adv,
	output logic o_sleep_mode,
	output logic o_power_down
);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic reg_hit(
		input logic [`PHYRS_ADDR_W-1:0] addr,
		input logic [`PHYRS_ADDR_W-1:0] off
	);
		reg_hit = (addr == off);
	endfunction : reg_hit

	localparam logic [`PHYRS_CNT_W-1:0] STRETCH_LOAD = `PHYRS_CNT_W'(STRETCH_CYCLES - 1);

	phyrs_bus_s bus;
	phyrs_state_s s_reg;
	phyrs_state_s s_next;

	assign bus = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		unique case (s_reg.state)
			PHYRS_ST_HOLD: begin
				// Straps are followed for the whole reset cycle; the last value sticks
				s_next.addr = i_addr_strap;
				s_next.pause = i_pause_strap;
				s_next.managed = ~i_management_disable_strap;
				s_next.cfg_sleep = i_sleep;
				if (i_ext_reset_b) begin
					s_next.state = PHYRS_ST_STRETCH;
					s_next.cnt = STRETCH_LOAD;
				end
			end
			PHYRS_ST_STRETCH: begin
				s_next.addr = i_addr_strap;
				s_next.pause = i_pause_strap;
				s_next.managed = ~i_management_disable_strap;
				s_next.cfg_sleep = i_sleep;
				if (!i_ext_reset_b) begin
					s_next.state = PHYRS_ST_HOLD;
				end else if (s_reg.cnt == '0) begin
					s_next.state = PHYRS_ST_RUN;
					s_next.soft_rst = 1'b0;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			PHYRS_ST_RUN: begin
				// Writes only land outside reset and only when managed
				if (bus.wr && s_reg.managed) begin
					if (reg_hit(bus.addr, `PHYRS_OFF_CTRL) &&
							bus.wdata[`PHYRS_CTRL_SOFT_RST_BIT]) begin
						s_next.soft_rst = 1'b1;
					end
					if (reg_hit(bus.addr, `PHYRS_OFF_CFG)) begin
						s_next.cfg_sleep = bus.wdata[`PHYRS_CFG_SLEEP_BIT];
					end
				end
				// Soft reset is seen the cycle after its write
				if (!i_ext_reset_b || s_reg.soft_rst) begin
					s_next.state = PHYRS_ST_HOLD;
				end
			end
			default: begin
				s_next.state = PHYRS_ST_HOLD;
			end
		endcase

		s_next.phy_reset = (s_next.state != PHYRS_ST_RUN);
		// Unmanaged: the pin rules live; managed: the register bit overrides it
		s_next.sleep = s_next.managed ? s_next.cfg_sleep : i_sleep;
		s_next.pwr_down = i_power_down_input;

		s_next.rd_data = `PHYRS_RST_DATA;
		if (bus.rd) begin
			if (reg_hit(bus.addr, `PHYRS_OFF_CTRL)) begin
				s_next.rd_data[`PHYRS_CTRL_SOFT_RST_BIT] = s_reg.soft_rst;
			end else if (reg_hit(bus.addr, `PHYRS_OFF_CFG)) begin
				s_next.rd_data[`PHYRS_CFG_SLEEP_BIT] = s_reg.cfg_sleep;
			end else if (reg_hit(bus.addr, `PHYRS_OFF_STAT)) begin
				s_next.rd_data[`PHYRS_STAT_RESET_BIT] = s_reg.phy_reset;
				s_next.rd_data[`PHYRS_STAT_PWRDN_BIT] = s_reg.pwr_down;
				s_next.rd_data[`PHYRS_STAT_SLEEP_BIT] = s_reg.sleep;
				s_next.rd_data[`PHYRS_STAT_MANAGED_BIT] = s_reg.managed;
				s_next.rd_data[`PHYRS_STAT_PAUSE_BIT] = s_reg.pause;
				s_next.rd_data[`PHYRS_STAT_ADDR_LSB +: 5] = s_reg.addr;
			end
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_reg <= '{
				state: PHYRS_ST_HOLD,
				cnt: '0,
				soft_rst: 1'b0,
				cfg_sleep: 1'b0,
				managed: 1'b0,
				addr: `PHYRS_RST_ADDR,
				pause: 1'b0,
				phy_reset: 1'b1,
				sleep: 1'b0,
				pwr_down: 1'b0,
				rd_data: `PHYRS_RST_DATA
			};
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_reg_rdata = s_reg.rd_data;
	assign o_phy_reset = s_reg.phy_reset;
	assign o_mgmt_addr = s_reg.addr;
	assign o_pause_adv = s_reg.pause;
	assign o_sleep_mode = s_reg.sleep;
	assign o_power_down = s_reg.pwr_down;

endmodule : phyrs_top
`default_nettype wire

// [dv/phyrs_board.sv]
// Board-side model: strap pins and external reset pin source
`timescale 1ns/1ps
`default_nettype none
module phyrs_board (
	input wire logic i_clk,
	input wire logic [9:0] i_want,
	output var logic [9:0] o_pins
);
	initial o_pins = 10'h000;
	// Pins move just after an edge, as a board driver would
	always @(posedge i_clk) o_pins <= i_want;
endmodule : phyrs_board
`default_nettype wire

// [dv/phyrs_checker.sv]
// Port assertions for the reset, strap and power-mode block
`timescale 1ns/1ps
`default_nettype none
module phyrs_checker #(parameter int unsigned STRETCH_CYCLES = 8) (
	input wire logic i_sys_clk, i_rst_b, i_ext_reset_b, i_pause_strap, i_sleep,
	input wire logic i_power_down_input, i_management_disable_strap, i_reg_wr, i_reg_rd,
	input wire logic [4:0] i_addr_strap, o_mgmt_addr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata, o_reg_rdata,
	input wire logic o_phy_reset, o_pause_adv, o_sleep_mode, o_power_down
);
	// Load edge plus one edge per count: reset drops one edge after zero
	localparam int LIM = STRETCH_CYCLES + 1;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	a_pin_reset: assert property (!i_ext_reset_b |-> ##2 o_phy_reset)
		else $error("pin reset");
	a_soft_reset: assert property (i_reg_wr && i_reg_addr == 8'h00 && i_reg_wdata[15]
		&& !o_phy_reset && !i_management_disable_strap |-> ##[3:4] o_phy_reset) else $error("soft");
	a_stretch_len: assert property ($rose(i_ext_reset_b) |-> ##LIM !o_phy_reset && $past(o_phy_reset))
		else $error("stretch");
	a_addr_latch: assert property ($fell(o_phy_reset) |-> o_mgmt_addr == $past(i_addr_strap))
		else $error("addr");
	a_pause_latch: assert property ($fell(o_phy_reset) |-> o_pause_adv == $past(i_pause_strap))
		else $error("pause");
	a_sleep_live: assert property (i_management_disable_strap && !o_phy_reset
		|=> o_sleep_mode == $past(i_sleep)) else $error("sleep");
	a_pwr_follow: assert property (1'b1 |=> o_power_down == $past(i_power_down_input))
		else $error("power down");
	a_rdata_quiet: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000) else $error("rdata");
endmodule : phyrs_checker
bind phyrs_top phyrs_checker #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (.*);
`default_nettype wire

// [dv/phyrs_top_tb.sv]
// Self-checking bench for the reset, strap and power-mode block
`timescale 1ns/1ps
`default_nettype none
module phyrs_top_tb;
	logic i_sys_clk = 0, i_rst_b = 0, wr = 0, rd = 0, rst_o, pause_o, sleep_o, pd_o;
	logic [7:0] ad = 0;
	logic [15:0] wd = 0, rdata;
	logic [9:0] want = 0, pins;
	logic [4:0] addr_o, sa;
	logic sp;
	logic [15:0] expq[$];
	logic [15:0] exp_now, seen_pins;
	int failures = 0, comparisons = 0;
	initial forever #2.5 i_sys_clk = ~i_sys_clk;
	phyrs_board u_board (.i_clk(i_sys_clk), .i_want(want), .o_pins(pins));
	phyrs_top #(.STRETCH_CYCLES(8)) u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_ext_reset_b(pins[9]), .i_management_disable_strap(pins[8]),
		.i_power_down_input(pins[7]), .i_sleep(pins[6]), .i_pause_strap(pins[5]),
		.i_addr_strap(pins[4:0]), .i_reg_addr(ad), .i_reg_wdata(wd), .i_reg_wr(wr),
		.i_reg_rd(rd), .o_reg_rdata(rdata), .o_phy_reset(rst_o), .o_mgmt_addr(addr_o),
		.o_pause_adv(pause_o), .o_sleep_mode(sleep_o), .o_power_down(pd_o));
	task automatic report_and_stop;
		if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: read %h, expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [15:0] stat(logic m, logic p, logic s, logic ps, logic [4:0] a);
		return {1'b0, p, s, m, 3'h0, ps, 3'h0, a};
	endfunction : stat
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		if (!w) expq.push_back(d);
		wr <= w;
		rd <= !w;
		ad <= a;
		wd <= d;
		@(posedge i_sys_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge i_sys_clk);
	endtask : acc
	task automatic wait_run;
		int n;
		n = 0;
		repeat (5) @(posedge i_sys_clk);
		while (rst_o !== 1'b0) begin
			if (++n > 200) begin
				failures++;
				report_and_stop;
			end
			@(negedge i_sys_clk);
		end
		@(posedge i_sys_clk);
	endtask : wait_run
	task automatic boot(input logic [9:0] p);
		i_rst_b <= 1'b0;
		want <= p;
		repeat (12) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		want[9] <= 1'b1;
		wait_run;
	endtask : boot
	task automatic wiggle(input int b);
		repeat (30) begin
			want[b] <= 1'($urandom);
			@(posedge i_sys_clk);
		end
	endtask : wiggle
	// Read data stands only in the cycle after the read strobe
	always @(posedge i_sys_clk) if (rd) begin
		@(negedge i_sys_clk);
		exp_now = expq.pop_front();
		check(rdata, exp_now);
		// Status reads are taken while stable, so the output pins must agree too
		if (ad == 8'h08) begin
			seen_pins = stat(exp_now[12], pd_o, sleep_o, pause_o, addr_o) | {rst_o, 15'h0};
			check(seen_pins, exp_now);
		end
	end
	initial begin
		void'($urandom(32'h147486a9));
		sa = 5'($urandom);
		sp = 1'($urandom);
		boot({4'h1, sp, sa});
		acc(0, 8'h04, 16'h0040);
		acc(0, 8'h08, stat(1, 0, 1, sp, sa));
		// Straps moved in run must not reach the latched copies
		want[6:0] <= {1'b0, ~sp, ~sa};
		acc(0, 8'h08, stat(1, 0, 1, sp, sa));
		acc(1, 8'h04, 16'h0000);
		acc(0, 8'h08, stat(1, 0, 0, sp, sa));
		acc(0, 8'h0c, 16'h0000);
		acc(1, 8'h00, 16'h8000);
		acc(0, 8'h00, 16'h8000);
		wait_run;
		acc(0, 8'h00, 16'h0000);
		acc(0, 8'h08, stat(1, 0, 0, ~sp, ~sa));
		wiggle(7);
		want[7] <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		acc(0, 8'h08, stat(1, 1, 0, ~sp, ~sa));
		want[9] <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		want[9] <= 1'b1;
		wait_run;
		boot(10'h100);
		acc(1, 8'h04, 16'h0040);
		acc(0, 8'h04, 16'h0000);
		wiggle(6);
		report_and_stop;
	end
endmodule : phyrs_top_tb
`default_nettype wire
